//--- verilog/wdt_defs.svh
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// period select encodings
`define PSEL_2P15      2'h0
`define PSEL_2P18      2'h1
`define PSEL_2P21      2'h2
`define PSEL_2P24      2'h3

// timeout exponents, in powers of two system clocks
`define EXP_2P15       5'h0F
`define EXP_2P18       5'h12
`define EXP_2P21       5'h15
`define EXP_2P24       5'h18

// width of the main counter, enough for 2^24
`define WDT_CNT_W      25

// reset window after the interrupt timeout, in system clocks
`define RST_WIN_CYC    10'h200
`define RST_WIN_W      10

// length of the reset pulse driven out, in system clocks
`define RST_PULSE_CYC  4'h8

`endif

//--- verilog/wdt_pkg.sv
package wdt_pkg;

  // phase of the watchdog sequence
  typedef enum logic [1:0] {
    ST_COUNT,
    ST_RST_WIN,
    ST_RESET
  } wdt_state_type;

  // software controls, carried together
  typedef struct packed {
    logic       restart;
    logic       int_enable;
    logic [1:0] period_select;
  } wdt_ctrl_type;

endpackage

//--- verilog/wdt_period_decode.sv
`timescale 1ns/1ps
`include "wdt_defs.svh"

// ----------------------------------------------------------------
// period decode: terminal count for the selected interrupt timeout
// ----------------------------------------------------------------
module wdt_period_decode (
  // selection
  input  wire logic [1:0]               period_select,
  // terminal count, timeout minus one
  output logic      [`WDT_CNT_W-1:0]    term_count
);

  // one-hot power of two, minus one gives the last count value
  always_comb begin
    unique case (period_select)
      `PSEL_2P15: term_count = (`WDT_CNT_W'(1) << `EXP_2P15) - `WDT_CNT_W'(1); // R2
      `PSEL_2P18: term_count = (`WDT_CNT_W'(1) << `EXP_2P18) - `WDT_CNT_W'(1); // R2
      `PSEL_2P21: term_count = (`WDT_CNT_W'(1) << `EXP_2P21) - `WDT_CNT_W'(1); // R2
      `PSEL_2P24: term_count = (`WDT_CNT_W'(1) << `EXP_2P24) - `WDT_CNT_W'(1); // R2
    endcase
  end

endmodule // wdt_period_decode

//--- verilog/watchdog_timeout_reset.sv
`timescale 1ns/1ps
`include "wdt_defs.svh"

// ----------------------------------------------------------------
// watchdog with interrupt timeout and delayed system reset
// ----------------------------------------------------------------

// Overview of operation
// R1 - counter runs always, restart clears it to zero except during the reset pulse
// R2 - two-bit select picks 2^15/18/21/24 clocks
// R3 - timeout raises interrupt only when enabled
// R4 - timeout opens a 512-clock reset window
// R5 - window expiry without restart asserts system reset
// R6 - software restarts sooner than selected timeout
// R7 - interrupt optional, reset always happens
// R8 - restart in window cancels reset, new interval
module watchdog_timeout_reset (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  // software controls
  input  wire wdt_pkg::wdt_ctrl_type ctrl,
  // event outputs
  output logic                       wdt_irq,
  output logic                       wdt_timeout_flag,
  output logic                       sys_reset
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  wdt_pkg::wdt_state_type  state_q, state_d;       // sequence phase
  logic [`WDT_CNT_W-1:0]   cnt_q, cnt_d;           // interval counter
  logic [`RST_WIN_W-1:0]   win_q, win_d;           // reset window counter
  logic [3:0]              pulse_q, pulse_d;       // reset pulse length
  logic                    irq_q, irq_d;           // interrupt pulse
  logic                    flag_q, flag_d;         // timeout level
  logic                    rst_q, rst_d;           // system reset level
  logic [`WDT_CNT_W-1:0]   term_count;             // selected last count

  // period decode lives apart so the table is in one place
  wdt_period_decode u_decode (
    .period_select (ctrl.period_select),
    .term_count    (term_count)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q + `WDT_CNT_W'(1);               // R1
    win_d   = win_q;
    pulse_d = pulse_q;
    irq_d   = 1'b0;
    flag_d  = flag_q;
    rst_d   = 1'b0;
    unique case (state_q)
      wdt_pkg::ST_COUNT: begin
        if (ctrl.restart) begin
          cnt_d = '0;                                  // R1
        end else if (cnt_q >= term_count) begin
          // compare is >= so a shrunk period still times out at once
          irq_d   = ctrl.int_enable;                   // R3 R7
          flag_d  = 1'b1;
          cnt_d   = '0;
          win_d   = `RST_WIN_CYC - `RST_WIN_W'(1);    // R4
          state_d = wdt_pkg::ST_RST_WIN;
        end
      end
      wdt_pkg::ST_RST_WIN: begin
        if (ctrl.restart) begin
          // restart here cancels the pending reset
          cnt_d   = '0;                                // R8
          flag_d  = 1'b0;
          state_d = wdt_pkg::ST_COUNT;
        end else if (win_q == '0) begin
          // reset does not depend on the interrupt enable
          rst_d   = 1'b1;                              // R5 R7
          pulse_d = `RST_PULSE_CYC - 4'h1;
          state_d = wdt_pkg::ST_RESET;
        end else begin
          win_d = win_q - `RST_WIN_W'(1);              // R4
        end
      end
      wdt_pkg::ST_RESET: begin
        // hold reset a few clocks; the system reset tree acts on it
        if (pulse_q == '0) begin
          cnt_d   = '0;
          flag_d  = 1'b0;
          state_d = wdt_pkg::ST_COUNT;
        end else begin
          rst_d   = 1'b1;                              // R5
          pulse_d = pulse_q - 4'h1;
        end
      end
      default: begin
        state_d = wdt_pkg::ST_COUNT;
        cnt_d   = '0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= wdt_pkg::ST_COUNT;
      cnt_q   <= '0;
      win_q   <= '0;
      pulse_q <= '0;
      irq_q   <= 1'b0;
      flag_q  <= 1'b0;
      rst_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      win_q   <= win_d;
      pulse_q <= pulse_d;
      irq_q   <= irq_d;
      flag_q  <= flag_d;
      rst_q   <= rst_d;
    end
  end

  assign wdt_irq          = irq_q;
  assign wdt_timeout_flag = flag_q;
  assign sys_reset        = rst_q;

  // ----------------------------------------------------------------
  // checking aid: clocks spent in the reset window
  // ----------------------------------------------------------------
  // one bit wider than the window counter; it counts up to 512, which 10 bits would hold
  localparam int WIN_AGE_W = `RST_WIN_W + 1;

  logic [WIN_AGE_W-1:0]    win_age_q, win_age_d;   // window age in clocks

  // count only while waiting for a restart, clear elsewhere
  always_comb begin
    win_age_d = '0;
    if (state_q == wdt_pkg::ST_RST_WIN) begin
      win_age_d = win_age_q + WIN_AGE_W'(1);
    end
  end

  // register only; it feeds the assertions and is pruned in silicon
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      win_age_q <= '0;
    end else begin
      win_age_q <= win_age_d;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_window_quiet;
    !ctrl.restart [*8];
  endsequence

  // the reset pulse: held for its full length, then dropped
  sequence s_reset_held;
    sys_reset [*8] ##1 !sys_reset;
  endsequence

  a_restart_clears_cnt: assert property ( // R1
    ctrl.restart && state_q != wdt_pkg::ST_RESET |=> cnt_q == '0)
    else $error("restart did not clear counter");

  a_cnt_increments: assert property ( // R1
    state_q == wdt_pkg::ST_COUNT && !ctrl.restart && cnt_q < term_count |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("counter did not advance");

  a_period_decode: assert property ( // R2
    term_count == ((`WDT_CNT_W'(1) << (5'h0F + 5'(ctrl.period_select) * 5'h3)) - 1'b1))
    else $error("period decode wrong");

  a_irq_when_enabled: assert property ( // R3
    state_q == wdt_pkg::ST_COUNT && !ctrl.restart && cnt_q >= term_count && ctrl.int_enable |=> wdt_irq)
    else $error("interrupt missing on timeout");

  a_irq_masked: assert property ( // R7
    !$past(ctrl.int_enable) |-> !wdt_irq)
    else $error("interrupt raised while disabled");

  a_window_start: assert property ( // R4
    $rose(state_q == wdt_pkg::ST_RST_WIN) |-> win_q == `RST_WIN_CYC - 1'b1)
    else $error("reset window loaded wrong");

  a_reset_on_expiry: assert property ( // R5
    state_q == wdt_pkg::ST_RST_WIN && win_q == '0 && !ctrl.restart |=> sys_reset)
    else $error("reset missing at window end");

  a_no_early_reset: assert property ( // R4
    $rose(state_q == wdt_pkg::ST_RST_WIN) ##0 s_window_quiet |-> !sys_reset)
    else $error("reset came early");

  a_restart_cancels: assert property ( // R8
    state_q == wdt_pkg::ST_RST_WIN && ctrl.restart |=> state_q == wdt_pkg::ST_COUNT && !sys_reset)
    else $error("restart did not cancel reset");

  a_irq_one_cycle: assert property ( // R3
    wdt_irq |=> !wdt_irq)
    else $error("interrupt longer than one cycle");

  a_irq_sets_flag: assert property ( // R3
    wdt_irq |-> wdt_timeout_flag)
    else $error("interrupt without timeout flag");

  a_window_length: assert property ( // R4
    $rose(sys_reset) |-> win_age_q == `RST_WIN_CYC)
    else $error("reset window length wrong");

  a_reset_pulse_len: assert property ( // R5
    $rose(sys_reset) |-> s_reset_held)
    else $error("reset pulse length wrong");

  a_reset_holds_on: assert property ( // R5
    state_q == wdt_pkg::ST_RESET && pulse_q != '0 |=> sys_reset)
    else $error("reset pulse cut short");

  a_cancel_clears_flag: assert property ( // R8
    state_q == wdt_pkg::ST_RST_WIN && ctrl.restart |=> !wdt_timeout_flag)
    else $error("restart left timeout flag set");

endmodule // watchdog_timeout_reset

//--- bench/tb_watchdog_timeout_reset.sv
`timescale 1ns/1ps

// --------------------------------------------------------------
// bench for the watchdog with interrupt timeout and system reset
// --------------------------------------------------------------
module tb_watchdog_timeout_reset;
  // shortest timeout, select 00, in system clocks
  localparam int unsigned T0 = 32'h0000_8000;
  // reset window after the interrupt timeout, in system clocks
  localparam int unsigned WIN = 32'd512;

  logic                  clk_sys;          // system clock, 8 ns
  logic                  rst_b;            // async reset, active low
  wdt_pkg::wdt_ctrl_type ctrl;             // software controls
  logic                  wdt_irq;          // interrupt pulse
  logic                  wdt_timeout_flag; // timeout level
  logic                  sys_reset;        // system reset pulse
  int                    fails;            // mismatches seen
  int                    checks_done;      // comparisons made
  int                    n;                // clocks since last restart
  int                    irqs;             // interrupt cycles seen
  int                    resets;           // reset cycles seen
  int                    m;                // reset pulse length

  watchdog_timeout_reset DUT (
    // clock and reset
    .clk_sys          (clk_sys),
    .rst_b            (rst_b),
    // software controls
    .ctrl             (ctrl),
    // event outputs
    .wdt_irq          (wdt_irq),
    .wdt_timeout_flag (wdt_timeout_flag),
    .sys_reset        (sys_reset)
  );

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  // free-running clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // compare four-state values, an unknown matches only an unknown
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask

  // one clock, outputs sampled at the falling edge where settled
  task automatic step();
    @(negedge clk_sys);
    n++;
    irqs   += (wdt_irq === 1'b1);
    resets += (sys_reset === 1'b1);
  endtask

  // restart held across exactly one rising edge
  task automatic restart_now();
    @(negedge clk_sys);
    ctrl.restart = 1'b1;
    @(negedge clk_sys);
    ctrl.restart = 1'b0;
    n      = 0;
    irqs   = 0;
    resets = 0;
  endtask

  // bounded wait for the timeout level
  task automatic wait_flag();
    while (wdt_timeout_flag !== 1'b1 && n < T0 + 16) step();
  endtask

  // ends the run, called by the main sequence and the watchdog
  task automatic give_verdict();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  // enabled interrupt, then unserviced window leads to reset
  task automatic enabled_timeout();
    ctrl.int_enable    = 1'b1;
    ctrl.period_select = 2'h0;
    restart_now();
    wait_flag();
    check(n, T0, "timeout length");
    check(wdt_irq, 1'b1, "interrupt at timeout");
    while (sys_reset !== 1'b1 && n < T0 + 600) step();
    check(n, T0 + WIN, "reset after window");
    check(wdt_timeout_flag, 1'b1, "flag during reset");
    m = 0;
    while (sys_reset === 1'b1 && m < 20) begin
      step();
      m++;
    end
    check(m, 8, "reset pulse length");
    check(irqs, 1, "single interrupt cycle");
    check(wdt_timeout_flag, 1'b0, "flag after reset");
  endtask

  // restarts keep it quiet; disabled interrupt; restart in window
  task automatic disabled_restart();
    ctrl.int_enable    = 1'b0;
    ctrl.period_select = 2'h3;
    restart_now();
    // longer selections outlast the shortest timeout together
    for (int s = 3; s > 0; s--) begin
      ctrl.period_select = s[1:0];
      repeat (11000) step();
      check(wdt_timeout_flag, 1'b0, "no early timeout");
    end
    // shrinking the period below the count times out at once, masked
    ctrl.period_select = 2'h0;
    n      = 0;
    irqs   = 0;
    resets = 0;
    while (sys_reset !== 1'b1 && n < WIN + 16) step();
    check(n, WIN + 1, "reset with interrupt off");
    repeat (8) step();
    check(resets, 8, "masked reset pulse");
    check(irqs, 0, "no interrupt before reset");
    restart_now();
    wait_flag();
    check(n, T0, "count cleared by restart");
    check(irqs, 0, "masked interrupt");
    repeat (500) step();
    restart_now();
    check(wdt_timeout_flag, 1'b0, "flag cleared by restart");
    repeat (600) step();
    check(resets, 0, "reset cancelled");
    check(wdt_timeout_flag, 1'b0, "serviced in time");
    check(irqs, 0, "still masked");
  endtask

  // --------------------------------------------------------------
  // main sequence and watchdog
  // --------------------------------------------------------------
  initial begin
    fails       = 0;
    checks_done = 0;
    ctrl        = '0;
    rst_b       = 1'b0;
    repeat (5) @(negedge clk_sys);
    rst_b = 1'b1;
    enabled_timeout();
    disabled_restart();
    give_verdict();
  end

  // cut a hang short; both scenarios need a little over 100k clocks
  initial begin
    repeat (110000) @(posedge clk_sys);
    fails++;
    give_verdict();
  end
endmodule // tb_watchdog_timeout_reset
